// ### inc/qdm_pkg.sv
// Purpose: constants and types for the quadrature decoder and motor extensions
// Assumes: byte address on an 8-bit plain register port, 32-bit data
// Notes: channel registers sit at channel*0x40 plus the channel offset
//
// Summary of operation
// - each encoder input may be inverted; phase a and b may be exchanged
// - with filtering on, pulses shorter than filter_length+1 clocks are blocked
// - with glitch_suppress_en clear, filters are bypassed completely
// - rotation sense flag is readable any time and follows inversion and swap
// - every direction reversal sets a sticky flag in quad_status_reg
// - reversal needs two same-phase edges sampling equal level, then other-phase edge
// - decode_transparent disables reversal detection; filtering and edges keep working
// - edges on a and b closer than filter_length+1 clocks set quad_error_flag
// - position mode counts phase edges in channel 0, index pulses in channel 1
// - channel 0 and 1 counter values read out to form a 32-bit position
// - in position mode, channel 0 counter clears whenever the channel 1 index count steps
// - decoded direction makes channels 0 and 1 count up or down
// - decoder plus speed mode routes channel 2 time base to channel 0 a input
// - speed mode captures channel 0 count into a and clears it each period
// - gray_count_en in waveform drives 2-bit gray on a/b, period from c
// - write lock discards writes to mode, fault, stepper, a, b and c registers
// - lock enable changes only with key 0x54494D in the same write
// - fault output from channel 0 and/or 1 c compare flags, each enabled
// - with decoder_en clear, pins reach counters unchanged, no filter or decode
// - filter_length accepts 0 through 63
// - index_on_phase_b_pin takes index from channel 0 b pin
package qdm_pkg;
   localparam int NUM_CH = 3;
   localparam int CNT_W = 16;
   localparam int FILT_W = 6;
   localparam logic [5:0] OFF_CCR = 6'h00;
   localparam logic [5:0] OFF_CMR = 6'h04;
   localparam logic [5:0] OFF_SMMR = 6'h08;
   localparam logic [5:0] OFF_CV = 6'h10;
   localparam logic [5:0] OFF_RA = 6'h14;
   localparam logic [5:0] OFF_RB = 6'h18;
   localparam logic [5:0] OFF_RC = 6'h1C;
   localparam logic [5:0] OFF_SR = 6'h20;
   localparam logic [7:0] OFF_BMR = 8'hC4;
   localparam logic [7:0] OFF_QISR = 8'hD4;
   localparam logic [7:0] OFF_FMR = 8'hD8;
   localparam logic [7:0] OFF_WPMR = 8'hE4;
   localparam int CCR_COUNT_CLOCK_ON = 0;
   localparam int CCR_CLKDIS = 1;
   localparam int CCR_SW_TRIGGER_CMD = 2;
   localparam int CMR_WAVE = 15;
   localparam int SMMR_GRAY_COUNT_EN = 0;
   localparam int SMMR_DOWN = 1;
   localparam int SR_C_COMPARE_FLAG = 4;
   localparam int QISR_DIR = 8;
   localparam int WPMR_EN = 0;
   localparam logic [23:0] LOCK_KEY = 24'h54_494D;
   localparam logic [31:0] BMR_RST = 32'h0000_0000;
   localparam logic [15:0] CMR_RST = 16'h0000;
   localparam logic [1:0] FMR_RST = 2'h0;

   typedef struct packed {
      logic [5:0] rsv_hi;
      logic [5:0] filter_length;
      logic glitch_suppress_en;
      logic rsv_18;
      logic index_on_phase_b_pin;
      logic phase_swap;
      logic index_invert;
      logic phase_b_invert;
      logic phase_a_invert;
      logic edge_on_a_only;
      logic decode_transparent;
      logic speed_meas_en;
      logic position_meas_en;
      logic decoder_en;
      logic [7:0] rsv_lo;
   } qdm_bmr_t;
endpackage

// ### rtl/qdm_top.sv
// Purpose: quadrature decoder front end, position/speed steering, gray stepper, lock, fault
// Assumes: encoder pins asynchronous to sys_clk_in; one register access per strobe
// Notes: channel counters are a reduced model: capture counting or waveform up to c
`timescale 1ns/1ps
module qdm_top #(
   parameter int CNT_W = qdm_pkg::CNT_W
) (
   input wire logic sys_clk_in,              // 200 MHz master clock
   input wire logic rst_n_in,                // async reset, active low
   input wire logic [7:0] addr_in,           // register byte address
   input wire logic [31:0] wr_data_in,       // write data
   input wire logic wr_en_in,                // write strobe
   input wire logic rd_en_in,                // read strobe
   input wire logic phase_a_in,              // channel 0 a pin, encoder phase a
   input wire logic phase_b_in,              // channel 0 b pin, encoder phase b
   input wire logic index_in,                // channel 1 a pin, encoder index
   output logic [31:0] rd_data_out,          // read data, cycle after rd_en_in
   output logic [2:0] chan_a_out,            // channel a outputs
   output logic [2:0] chan_b_out,            // channel b outputs
   output logic [2:0] chan_oe_n_out,         // low while channel drives its pins
   output logic fault_out                    // fault output
);
   localparam int N = qdm_pkg::NUM_CH;

   function automatic logic ch_hit(input logic [7:0] a, input logic [1:0] c,
                                   input logic [5:0] o);
      return (a[7:6] == c) && (a[5:0] == o);
   endfunction

   function automatic logic [1:0] gray_step(input logic [1:0] g, input logic dn);
      return dn ? {~g[0], g[1]} : {g[0], ~g[1]};
   endfunction

   // pin synchronisers
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else begin
         sync1_r <= {index_in, phase_b_in, phase_a_in};
         sync2_r <= sync1_r;
      end
   end

   logic [31:0] bmr_r;
   qdm_pkg::qdm_bmr_t bmr;
   assign bmr = qdm_pkg::qdm_bmr_t'(bmr_r);

   // conditioning: inversion, swap, index pin choice
   wire pa_inv = sync2_r[0] ^ bmr.phase_a_invert;
   wire pb_inv = sync2_r[1] ^ bmr.phase_b_invert;
   wire idx_pin = bmr.index_on_phase_b_pin ? sync2_r[1] : sync2_r[2];
   wire [2:0] cond = {idx_pin ^ bmr.index_invert,
                      bmr.phase_swap ? pa_inv : pb_inv,
                      bmr.phase_swap ? pb_inv : pa_inv};

   // stability filters, filter_length is a 6-bit field (0..63)
   logic [qdm_pkg::FILT_W-1:0] fcnt_r [3];
   logic [2:0] filt_r;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               fcnt_r[gi] <= '0;
               filt_r[gi] <= 1'b0;
            end else if (cond[gi] == filt_r[gi]) begin
               fcnt_r[gi] <= '0;
            end else if (fcnt_r[gi] >= bmr.filter_length) begin
               filt_r[gi] <= cond[gi];
               fcnt_r[gi] <= '0;
            end else begin
               fcnt_r[gi] <= fcnt_r[gi] + 1'b1;
            end
         end
      end
   endgenerate

   wire [2:0] qin = bmr.glitch_suppress_en ? filt_r : cond;

   // edges
   logic [2:0] qprev_r;
   logic [2:0] rawprev_r;
   logic tbprev_r;
   logic [2:0] a_r;
   wire qd = bmr.decoder_en;
   wire pos = qd & bmr.position_meas_en;
   wire spd = qd & bmr.speed_meas_en;
   wire [2:0] edges = qd ? (qin ^ qprev_r) : 3'h0;
   wire idx_rise = edges[2] & qin[2];
   wire [2:0] raw_rise = sync2_r & ~rawprev_r;
   wire any_edge = edges[0] | edges[1];
   wire cnt_ev = bmr.edge_on_a_only ? edges[0] : any_edge;
   wire tb_rise = a_r[2] & ~tbprev_r;

   // direction change detection
   logic last_ph_r;
   logic samp_r;
   logic dir_r;
   logic [1:0] same_r;
   logic [qdm_pkg::FILT_W-1:0] gap_r;
   wire ph = ~edges[0];
   wire smp = ph ? qin[0] : qin[1];
   wire same_ph = ph == last_ph_r;
   wire dir_chg = any_edge & ~same_ph & (same_r == 2'd2)
                  & ~bmr.decode_transparent;
   wire quad_error_flag_ev = (edges[0] & edges[1])
                  | (any_edge & ~same_ph & (gap_r < bmr.filter_length));
   wire [1:0] same_nxt = (same_ph && smp == samp_r) ?
                         ((same_r == 2'd2) ? same_r : same_r + 1'b1) : 2'd1;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         qprev_r <= 3'h0;
         rawprev_r <= 3'h0;
         tbprev_r <= 1'b0;
         last_ph_r <= 1'b0;
         samp_r <= 1'b0;
         same_r <= 2'd0;
         dir_r <= 1'b0;
         gap_r <= '1;
      end else begin
         qprev_r <= qin;
         rawprev_r <= sync2_r;
         tbprev_r <= a_r[2];
         if (any_edge) begin
            last_ph_r <= ph;
            samp_r <= smp;
            same_r <= same_nxt;
            gap_r <= '0;
         end else if (gap_r != '1) begin
            gap_r <= gap_r + 1'b1;
         end
         if (dir_chg) begin
            dir_r <= ~dir_r;
         end
      end
   end

   // register port decode
   wire [1:0] ch = addr_in[7:6];
   wire ch_ok = ch != 2'd3;
   wire [1:0] chi = ch_ok ? ch : 2'd0;
   logic wp_r;
   wire wr_ok = wr_en_in & ~wp_r;
   wire key_ok = wr_data_in[31:8] == qdm_pkg::LOCK_KEY;
   wire wpmr_wr = wr_en_in & (addr_in == qdm_pkg::OFF_WPMR) & key_ok;
   wire qisr_rd = rd_en_in & (addr_in == qdm_pkg::OFF_QISR);

   logic [15:0] cmr_r [N];
   logic [1:0] smmr_r [N];
   logic [CNT_W-1:0] ra_r [N];
   logic [CNT_W-1:0] rb_r [N];
   logic [CNT_W-1:0] rc_r [N];
   logic [CNT_W-1:0] cv_r [N];
   logic [1:0] gray_r [N];
   logic [2:0] clk_on_r;
   logic [2:0] c_compare_flag_r;
   logic [2:0] b_r;
   logic [2:0] oe_n_r;
   logic [1:0] fmr_r;
   logic [2:0] qflag_r;
   logic fault_r;
   logic [31:0] rd_data_r;

   // per-channel steering
   logic [2:0] step;
   logic [2:0] clr;
   logic [2:0] capt;
   logic [2:0] wave;
   logic [2:0] cmp;
   logic [2:0] ccr_wr;
   logic [2:0] sw_trg;
   logic [2:0] sr_rd;
   logic [1:0] gray_nx [N];
   wire cnt_dn = qd & dir_r;
   assign step[0] = qd ? ((pos | spd) & cnt_ev) : raw_rise[0];
   assign step[1] = qd ? idx_rise : raw_rise[2];
   assign step[2] = 1'b0;
   assign clr[0] = (pos & step[1]) | (spd & tb_rise);
   assign clr[1] = 1'b0;
   assign clr[2] = 1'b0;
   assign capt[0] = spd & tb_rise;
   assign capt[1] = 1'b0;
   assign capt[2] = 1'b0;
   generate
      for (gi = 0; gi < N; gi++) begin : g_dec
         assign wave[gi] = cmr_r[gi][qdm_pkg::CMR_WAVE];
         assign cmp[gi] = cv_r[gi] == rc_r[gi];
         assign ccr_wr[gi] = wr_en_in & ch_hit(addr_in, 2'(gi), qdm_pkg::OFF_CCR);
         assign sw_trg[gi] = ccr_wr[gi] & wr_data_in[qdm_pkg::CCR_SW_TRIGGER_CMD];
         assign sr_rd[gi] = rd_en_in & ch_hit(addr_in, 2'(gi), qdm_pkg::OFF_SR);
         assign gray_nx[gi] = gray_step(gray_r[gi], smmr_r[gi][qdm_pkg::SMMR_DOWN]);
      end
   endgenerate

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < N; i++) begin
            cmr_r[i] <= qdm_pkg::CMR_RST;
            smmr_r[i] <= 2'h0;
            ra_r[i] <= '0;
            rb_r[i] <= '0;
            rc_r[i] <= '0;
            cv_r[i] <= '0;
            gray_r[i] <= 2'h0;
         end
         clk_on_r <= 3'h0;
         c_compare_flag_r <= 3'h0;
         a_r <= 3'h0;
         b_r <= 3'h0;
         oe_n_r <= 3'h7;
      end else begin
         for (int i = 0; i < N; i++) begin
            oe_n_r[i] <= ~wave[i];
            c_compare_flag_r[i] <= (c_compare_flag_r[i] & ~sr_rd[i]) | (clk_on_r[i] & cmp[i]);
            if (ccr_wr[i]) begin
               clk_on_r[i] <= (clk_on_r[i] | wr_data_in[qdm_pkg::CCR_COUNT_CLOCK_ON])
                              & ~wr_data_in[qdm_pkg::CCR_CLKDIS];
            end
            if (sw_trg[i]) begin
               cv_r[i] <= '0;
            end else if (clk_on_r[i]) begin
               if (wave[i]) begin
                  if (cmp[i]) begin
                     cv_r[i] <= '0;
                     if (smmr_r[i][qdm_pkg::SMMR_GRAY_COUNT_EN]) begin
                        gray_r[i] <= gray_nx[i];
                        a_r[i] <= gray_nx[i][1];
                        b_r[i] <= gray_nx[i][0];
                     end else begin
                        a_r[i] <= ~a_r[i];
                     end
                  end else begin
                     cv_r[i] <= cv_r[i] + 1'b1;
                  end
               end else if (clr[i]) begin
                  cv_r[i] <= '0;
               end else if (step[i]) begin
                  cv_r[i] <= cnt_dn ? cv_r[i] - 1'b1 : cv_r[i] + 1'b1;
               end
            end
            if (capt[i] & clk_on_r[i]) begin
               ra_r[i] <= cv_r[i];
            end
            if (wr_ok & ch_hit(addr_in, 2'(i), qdm_pkg::OFF_CMR)) begin
               cmr_r[i] <= wr_data_in[15:0];
            end
            if (wr_ok & ch_hit(addr_in, 2'(i), qdm_pkg::OFF_SMMR)) begin
               smmr_r[i] <= wr_data_in[1:0];
            end
            if (wr_ok & wave[i] & ch_hit(addr_in, 2'(i), qdm_pkg::OFF_RA)) begin
               ra_r[i] <= wr_data_in[CNT_W-1:0];
            end
            if (wr_ok & wave[i] & ch_hit(addr_in, 2'(i), qdm_pkg::OFF_RB)) begin
               rb_r[i] <= wr_data_in[CNT_W-1:0];
            end
            if (wr_ok & ch_hit(addr_in, 2'(i), qdm_pkg::OFF_RC)) begin
               rc_r[i] <= wr_data_in[CNT_W-1:0];
            end
         end
      end
   end

   // block registers, status flags, fault
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bmr_r <= qdm_pkg::BMR_RST;
         fmr_r <= qdm_pkg::FMR_RST;
         wp_r <= 1'b0;
         qflag_r <= 3'h0;
         fault_r <= 1'b0;
      end else begin
         if (wr_ok & (addr_in == qdm_pkg::OFF_BMR)) begin
            bmr_r <= wr_data_in;
         end
         if (wr_ok & (addr_in == qdm_pkg::OFF_FMR)) begin
            fmr_r <= wr_data_in[1:0];
         end
         if (wpmr_wr) begin
            wp_r <= wr_data_in[qdm_pkg::WPMR_EN];
         end
         // set wins over read-clear
         qflag_r <= (qflag_r & ~{3{qisr_rd}})
                    | {quad_error_flag_ev, dir_chg, idx_rise};
         fault_r <= (fmr_r[0] & c_compare_flag_r[0]) | (fmr_r[1] & c_compare_flag_r[1]);
      end
   end

   // read mux
   wire [5:0] off = addr_in[5:0];
   wire [CNT_W-1:0] ch_val = (off == qdm_pkg::OFF_CV) ? cv_r[chi] :
                             (off == qdm_pkg::OFF_RA) ? ra_r[chi] :
                             (off == qdm_pkg::OFF_RB) ? rb_r[chi] :
                             (off == qdm_pkg::OFF_RC) ? rc_r[chi] : '0;
   wire [31:0] ch_word = (off == qdm_pkg::OFF_CMR) ? {16'h0000, cmr_r[chi]} :
                         (off == qdm_pkg::OFF_SMMR) ? {30'h0, smmr_r[chi]} :
                         (off == qdm_pkg::OFF_SR) ? 32'(c_compare_flag_r[chi]) << qdm_pkg::SR_C_COMPARE_FLAG :
                         32'(ch_val);
   wire [31:0] qisr_word = (32'(dir_r) << qdm_pkg::QISR_DIR) | 32'(qflag_r);
   wire [31:0] rd_word = ch_ok ? ch_word :
                         (addr_in == qdm_pkg::OFF_BMR) ? bmr_r :
                         (addr_in == qdm_pkg::OFF_QISR) ? qisr_word :
                         (addr_in == qdm_pkg::OFF_FMR) ? {30'h0, fmr_r} :
                         (addr_in == qdm_pkg::OFF_WPMR) ? {31'h0, wp_r} : 32'h0000_0000;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_r <= 32'h0000_0000;
      end else begin
         rd_data_r <= rd_en_in ? rd_word : 32'h0000_0000;
      end
   end

   assign rd_data_out = rd_data_r;
   assign chan_a_out = a_r;
   assign chan_b_out = b_r;
   assign chan_oe_n_out = oe_n_r;
   assign fault_out = fault_r;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_filt_hold: assert property (bmr.glitch_suppress_en && $changed(filt_r[0])
      |-> $past(fcnt_r[0]) >= $past(bmr.filter_length))
      else $error("filter passed a level too early");
   a_filt_bypass: assert property (!bmr.glitch_suppress_en |-> qin == cond)
      else $error("filter not bypassed");
   a_dir_flip: assert property (dir_chg |=> dir_r != $past(dir_r) && qflag_r[1])
      else $error("direction change not recorded");
   a_dir_steady: assert property (!dir_chg |=> dir_r == $past(dir_r))
      else $error("direction moved without change condition");
   a_trans_off: assert property (bmr.decode_transparent |-> !dir_chg)
      else $error("change detected while transparent");
   a_quad_error_flag_flag: assert property (quad_error_flag_ev |=> qflag_r[2])
      else $error("quadrature error lost");
   a_idx_clear: assert property (pos && step[1] && clk_on_r[0] && !wave[0] && !sw_trg[0]
      |=> cv_r[0] == '0)
      else $error("position counter not cleared on index");
   a_speed_cap: assert property (capt[0] && clk_on_r[0] && !wave[0]
      |=> ra_r[0] == $past(cv_r[0]))
      else $error("speed capture wrong");
   a_lock_bmr: assert property (wp_r && wr_en_in && addr_in == qdm_pkg::OFF_BMR
      |=> bmr_r == $past(bmr_r))
      else $error("locked register written");
   a_key_check: assert property (wr_en_in && addr_in == qdm_pkg::OFF_WPMR && !key_ok
      |=> wp_r == $past(wp_r))
      else $error("lock changed with bad key");
   a_fault_out: assert property (fmr_r[0] && c_compare_flag_r[0] |=> fault_out)
      else $error("fault output missing");
   a_rd_idle: assert property (!rd_en_in |=> rd_data_out == 32'h0000_0000)
      else $error("read data outside read cycle");

   c_dir_change: cover property (dir_chg);
   c_quad_err: cover property (quad_error_flag_ev);
   c_speed_cap: cover property (capt[0] && clk_on_r[0]);
   c_lock_on: cover property (wpmr_wr && wr_data_in[0]);
endmodule

// ### verif/qdm_enc_model.sv
// Purpose: shaft encoder model driving phase a, phase b and index
// Assumes: steps are paced on the master clock edge
// Notes: levels are always driven; an encoder has no released state
`timescale 1ns/1ps
module qdm_enc_model (
   input wire logic clk_in,   // pacing clock
   output logic phase_a_out,  // quadrature phase a
   output logic phase_b_out,  // quadrature phase b
   output logic index_out     // once-per-turn index
);
   logic [1:0] pos_r = 2'h0;
   initial begin
      phase_a_out = 1'b0;
      phase_b_out = 1'b0;
      index_out = 1'b0;
   end
   // delta 1 forward, 3 backward, 2 moves both phases at once
   task automatic step(input logic [1:0] delta, input int hold);
      @(posedge clk_in);
      pos_r = pos_r + delta;
      phase_a_out <= pos_r[1] ^ pos_r[0];
      phase_b_out <= pos_r[1];
      repeat (hold) @(posedge clk_in);
   endtask
   task automatic spike(input int len, input int hold);
      @(posedge clk_in);
      phase_a_out <= ~phase_a_out;
      repeat (len) @(posedge clk_in);
      phase_a_out <= pos_r[1] ^ pos_r[0];
      repeat (hold) @(posedge clk_in);
   endtask
   task automatic pulse(input int len);
      @(posedge clk_in);
      index_out <= 1'b1;
      repeat (len) @(posedge clk_in);
      index_out <= 1'b0;
      repeat (len) @(posedge clk_in);
   endtask
endmodule

// ### verif/qdm_top_tb.sv
// Purpose: self-checking bench for the quadrature decoder and motor extensions
// Assumes: register port with read data in the cycle after the strobe
// Notes: fixed seed; the device is reset again before the speed and the fault sections
`timescale 1ns/1ps
module qdm_top_tb;
   localparam logic [31:0] POS = 32'h0000_0200;
   localparam logic [31:0] SPD = 32'h0000_0400;
   localparam logic [31:0] TRN = 32'h0000_0800;
   localparam logic [31:0] FLIP_A = 32'h0000_2000;
   localparam logic [31:0] FLIP_B = 32'h0000_4000;
   localparam logic [31:0] SWAP = 32'h0001_0000;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [2:0] ca, cb, coe;
   logic fault, pa, pb, ix;
   logic [31:0] v, q;
   logic [31:0] cfg[3] = '{FLIP_A, FLIP_A | FLIP_B, FLIP_A | FLIP_B | SWAP};
   logic [7:0] offs[6] = '{8'hC4, 8'hD8, 8'h04, 8'h08, 8'h1C, 8'h0C};
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   int fl, hold, n;

   qdm_top qdm_top_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .addr_in(addr),
      .wr_data_in(wdata), .wr_en_in(wr), .rd_en_in(rd), .phase_a_in(pa), .phase_b_in(pb),
      .index_in(ix), .rd_data_out(rdata), .chan_a_out(ca), .chan_b_out(cb),
      .chan_oe_n_out(coe), .fault_out(fault));
   qdm_enc_model qdm_enc_model_i (.clk_in(sys_clk), .phase_a_out(pa), .phase_b_out(pb),
      .index_out(ix));

   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(a, d);
      check(what, d, exp);
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask
   task automatic moves(input int cnt, input logic down, input int h);
      for (int i = 0; i < cnt; i++) qdm_enc_model_i.step(down ? 2'h3 : 2'h1, h);
   endtask
   function automatic logic [31:0] bmr(input int f, input logic [31:0] extra);
      return {6'h00, f[5:0], 1'b1, 19'h0_0100} | extra;
   endfunction
   // gray code successor, a output is the high bit
   function automatic logic [1:0] nxt_gray(input logic [1:0] g, input logic down);
      logic [1:0] k;
      k = {g[1], g[1] ^ g[0]};
      k = down ? k - 2'h1 : k + 2'h1;
      return {k[1], k[1] ^ k[0]};
   endfunction
   task automatic gray_run(input logic down);
      logic [1:0] prev;
      int t;
      @(posedge sys_clk);
      #1 prev = {ca[2], cb[2]};
      for (int i = 0; i < 6; i++) begin
         t = 0;
         while ({ca[2], cb[2]} === prev && t < 40) begin
            @(posedge sys_clk);
            #1 t++;
         end
         check("gray", {30'h0, ca[2], cb[2]}, {30'h0, nxt_gray(prev, down)});
         prev = {ca[2], cb[2]};
      end
   endtask

   initial begin
      void'($urandom(62881));
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      check("oe reset", {29'h0, coe}, 32'h0000_0007);
      foreach (offs[i]) rd_chk("reset value", offs[i], 32'h0000_0000);
      v = $urandom;
      v[0] = 1'b1;
      if (v[31:8] === qdm_pkg::LOCK_KEY) v[8] = ~v[8];
      wr_reg(qdm_pkg::OFF_WPMR, v);
      rd_chk("bad key", qdm_pkg::OFF_WPMR, 32'h0000_0000);
      wr_reg(qdm_pkg::OFF_WPMR, {qdm_pkg::LOCK_KEY, 8'h01});
      rd_chk("lock on", qdm_pkg::OFF_WPMR, 32'h0000_0001);
      wr_reg(qdm_pkg::OFF_FMR, 32'h0000_0003);
      wr_reg(8'h1C, 32'h0000_1234);
      rd_chk("fault mode locked", qdm_pkg::OFF_FMR, 32'h0000_0000);
      rd_chk("c locked", 8'h1C, 32'h0000_0000);
      v[0] = 1'b0;
      wr_reg(qdm_pkg::OFF_WPMR, v);
      rd_chk("lock kept", qdm_pkg::OFF_WPMR, 32'h0000_0001);
      wr_reg(qdm_pkg::OFF_WPMR, {qdm_pkg::LOCK_KEY, 8'h00});
      wr_reg(qdm_pkg::OFF_FMR, 32'h0000_0003);
      rd_chk("fault mode open", qdm_pkg::OFF_FMR, 32'h0000_0003);
      wr_reg(qdm_pkg::OFF_FMR, 32'h0000_0000);
      // decoder off: raw phase a rises, spike included
      wr_reg(8'h00, 32'h0000_0005);
      moves(8, 1'b0, 6);
      qdm_enc_model_i.spike(3, 6);
      rd_chk("raw count", 8'h10, 32'h0000_0003);
      fl = 1 + $urandom_range(9);
      hold = 2 * fl + 6;
      wr_reg(8'h04, 32'h0000_0000);
      wr_reg(8'h44, 32'h0000_0000);
      wr_reg(qdm_pkg::OFF_BMR, bmr(fl, POS));
      wr_reg(8'h00, 32'h0000_0005);
      wr_reg(8'h40, 32'h0000_0005);
      n = 4 + $urandom_range(11);
      moves(n, 1'b0, hold);
      qdm_enc_model_i.spike(fl, hold);
      rd_chk("position", 8'h10, 32'(n));
      qdm_enc_model_i.pulse(hold);
      rd_chk("turns", 8'h50, 32'h0000_0001);
      rd_chk("position cleared", 8'h10, 32'h0000_0000);
      rd_reg(qdm_pkg::OFF_QISR, q);
      check("no reversal", q & 32'h0000_0106, 32'h0000_0000);
      moves(8, 1'b0, hold);
      moves(6, 1'b1, hold);
      rd_reg(8'h10, v);
      check("count fell", {31'h0, v < 32'h0000_0008}, 32'h0000_0001);
      rd_reg(qdm_pkg::OFF_QISR, q);
      check("reversal", q & 32'h0000_0106, 32'h0000_0102);
      qdm_enc_model_i.step(2'h2, hold);
      rd_reg(qdm_pkg::OFF_QISR, q);
      check("quad error", q & 32'h0000_0004, 32'h0000_0004);
      moves(6, 1'b1, hold);
      foreach (cfg[i]) begin
         rd_reg(qdm_pkg::OFF_QISR, q);
         wr_reg(qdm_pkg::OFF_BMR, bmr(fl, POS | cfg[i]));
         moves(6, 1'b1, hold);
         rd_reg(qdm_pkg::OFF_QISR, q);
         check("apparent reversal", q & 32'h0000_0002, 32'h0000_0002);
      end
      rd_reg(qdm_pkg::OFF_QISR, q);
      wr_reg(qdm_pkg::OFF_BMR, bmr(fl, POS | TRN));
      moves(6, 1'b0, hold);
      rd_reg(qdm_pkg::OFF_QISR, q);
      check("transparent", q & 32'h0000_0002, 32'h0000_0000);
      // speed: 100-cycle time base, one edge every 10 cycles
      do_reset();
      wr_reg(qdm_pkg::OFF_BMR, bmr(2, SPD));
      wr_reg(8'h84, 32'h0000_C000);
      wr_reg(8'h9C, 32'h0000_0031);
      wr_reg(8'h04, 32'h0000_0500);
      wr_reg(8'h80, 32'h0000_0005);
      wr_reg(8'h00, 32'h0000_0005);
      moves(80, 1'b0, 9);
      rd_chk("speed", 8'h14, 32'h0000_000A);
      do_reset();
      for (int c = 0; c < 2; c++) begin
         wr_reg(8'(c * 64 + 4), 32'h0000_8000);
         wr_reg(8'(c * 64 + 28), 32'h0000_0005);
         wr_reg(8'(c * 64), 32'h0000_0005);
         #1 check("quiet", {31'h0, fault}, 32'h0000_0000);
         wr_reg(qdm_pkg::OFF_FMR, 32'(1 << c));
         n = 0;
         while (fault !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1 n++;
         end
         check("fault", {31'h0, fault}, 32'h0000_0001);
         check("oe", {31'h0, coe[c]}, 32'h0000_0000);
         wr_reg(qdm_pkg::OFF_FMR, 32'h0000_0000);
         repeat (2) @(posedge sys_clk);
      end
      wr_reg(8'h84, 32'h0000_8000);
      wr_reg(8'h9C, 32'h0000_0003);
      wr_reg(8'h88, 32'h0000_0001);
      wr_reg(8'h80, 32'h0000_0005);
      gray_run(1'b0);
      wr_reg(8'h88, 32'h0000_0003);
      gray_run(1'b1);
      conclude();
   end
endmodule
